// ===== servo_fault_pkg.sv
// servo fault manager constants, register map and carrier types
// assumes a 100 MHz control clock and an APB register master
package servo_fault_pkg;
  localparam int CLK_MHZ = 100;
  // self-resetting faults hold the stage off this long after clearing
  localparam int HOLDOFF_MS = 50;
  localparam int HOLDOFF_CYCLES = HOLDOFF_MS * 1000 * CLK_MHZ;
  // led blink timebase
  localparam int LED_TICK_MS = 100;
  localparam int LED_TICK_CYCLES = LED_TICK_MS * 1000 * CLK_MHZ;
  localparam logic [3:0] LED_ON_TICKS = 4'h2;
  localparam logic [3:0] LED_OFF_TICKS = 4'h2;
  localparam logic [3:0] LED_GAP_TICKS = 4'ha;
  localparam logic [2:0] INIT_TRIES = 3'h4;
  // following error is signed revolutions with 16 fraction bits
  localparam int FE_FRAC = 16;
  localparam logic signed [31:0] FE_LIMIT = 32'sh0080_0000;

  localparam int NF = 7;
  localparam int F_CFG = 0;
  localparam int F_COMM = 1;
  localparam int F_WDOG = 2;
  localparam int F_STEP = 3;
  localparam int F_POS = 4;
  localparam int F_AUX = 5;
  localparam int F_SYNC = 6;
  localparam logic [4:0] BLINK_CODE [NF] = '{5'h0c, 5'h11, 5'h12, 5'h13, 5'h13, 5'h14, 5'h14};

  typedef enum logic [1:0] {
    EXT_NONE, EXT_STEP_OVF, EXT_POS_OVF, EXT_AUX_FB
  } extended_fault_code_type;
  localparam extended_fault_code_type EXT_OF [NF] = '{EXT_NONE, EXT_NONE, EXT_NONE,
    EXT_STEP_OVF, EXT_POS_OVF, EXT_AUX_FB, EXT_NONE};

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [NF-1:0] CTRL_RESET = 7'h7f;
  localparam int ST_CODE = 8;
  localparam int ST_EXT = 16;
  localparam int ST_PWR = 20;
  localparam int ST_SUB = 24;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic serialCommFail;
    logic watchdogTimeout;
    logic gearStepOverflow;
    logic auxFeedbackFault;
    logic auxAbsoluteEncoderFault;
    logic auxThermistorFault;
    logic auxSerialDeviceFault;
    logic networkSyncLost;
  } fault_in_type;
endpackage

// ===== servo_fault_manager.sv
// servo fault supervision: latching, output stage gating, led blink code
// assumes fault inputs synchronous to clk; enableN is the drive enable input
//
// Operation
// - latch only faults of the latched class
// - any fault disables the power stage
// - active fault drives led blink code
// - self-resetting fault re-enables stage automatically
// - latched fault cleared by disable or power
// - hold stage off 50 ms after a self-resetting fault clears
// - report only the highest priority fault
// - after enable cycle report next fault
// - code 17 on feedback communication failure
// - code 18 on option card watchdog
// - code 19 with step size overflow
// - code 19 beyond 128 revs error
// - code 20 with auxiliary feedback fault
// - code 20 no extended on sync loss
// - four feedback setup tries before fault
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module servo_fault_manager #(
  parameter int HOLDOFF_COUNT = servo_fault_pkg::HOLDOFF_CYCLES,
  parameter int LED_TICK_COUNT = servo_fault_pkg::LED_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire servo_fault_pkg::apb_req_type apbReq,
  output servo_fault_pkg::apb_rsp_type apbRsp,
  input wire servo_fault_pkg::fault_in_type faultIn,
  input wire logic signed [31:0] followingError,
  input wire logic enableN,
  output logic initRequest,
  input wire logic initDone,
  input wire logic initOk,
  output logic powerStageEnable,
  output logic statusLed,
  output logic irq
);
  import servo_fault_pkg::*;

  typedef enum logic [1:0] {INIT_START, INIT_WAIT, INIT_OK, INIT_FAIL} init_state_type;
  typedef enum logic [1:0] {LED_IDLE, LED_ON, LED_OFF, LED_GAP} led_state_type;

  logic [NF-1:0] raw, latched, next_latched, active;
  logic [NF-1:0] latchClass, next_latchClass;
  logic [NF-1:0] irqStatus, next_irqStatus, irqMask, next_irqMask, activeQ;
  logic [2:0] reportIdx, next_reportIdx;
  logic reportValid, next_reportValid;
  logic [4:0] code;
  extended_fault_code_type extCode, next_extCode;
  logic [31:0] holdCnt, next_holdCnt;
  init_state_type initState, next_initState;
  logic [2:0] tries, next_tries;
  logic enW, rdW;
  logic [31:0] readWord, prdataQ, next_prdata;
  logic badAddr, pslverrQ, next_pslverr;
  logic feOver;

  assign feOver = (followingError > FE_LIMIT) || (followingError < -FE_LIMIT);

  always_comb begin
    raw = '0;
    raw[F_CFG] = (initState == INIT_FAIL);
    raw[F_COMM] = faultIn.serialCommFail;
    raw[F_WDOG] = faultIn.watchdogTimeout;
    raw[F_STEP] = faultIn.gearStepOverflow;
    raw[F_POS] = feOver;
    raw[F_AUX] = faultIn.auxFeedbackFault | faultIn.auxAbsoluteEncoderFault
      | faultIn.auxThermistorFault | faultIn.auxSerialDeviceFault;
    raw[F_SYNC] = faultIn.networkSyncLost;
  end

  // latched sources clear only while enable is in its disable state
  always_comb begin
    next_latched = enableN ? '0 : (latched | (raw & latchClass));
    active = raw | latched;
  end

  // feedback device setup, retried before declaring a configuration fault
  always_comb begin
    next_initState = initState;
    next_tries = tries;
    initRequest = 1'b0;
    unique case (initState)
      INIT_START: begin
        initRequest = 1'b1;
        next_tries = tries + 3'h1;
        next_initState = INIT_WAIT;
      end
      INIT_WAIT: begin
        if (initDone && initOk) begin
          next_initState = INIT_OK;
        end else if (initDone) begin
          next_initState = (tries == INIT_TRIES) ? INIT_FAIL : INIT_START;
        end
      end
      INIT_OK: next_initState = INIT_OK;
      INIT_FAIL: next_initState = INIT_FAIL;
    endcase
  end

  // selection only moves when idle, when enable is cycled or when the reported
  // fault clears, so the operator sees one code until it clears or the drive is reset
  always_comb begin
    next_reportIdx = reportIdx;
    next_reportValid = reportValid;
    next_extCode = extCode;
    if (!reportValid || enableN || !active[reportIdx]) begin
      next_reportValid = |active;
      next_reportIdx = '0;
      for (int i = NF - 1; i >= 0; i--) begin
        if (active[i]) begin
          next_reportIdx = 3'(i);
        end
      end
      next_extCode = EXT_OF[next_reportIdx];
    end
  end
  assign code = reportValid ? BLINK_CODE[reportIdx] : 5'h00;

  // counts down only once no self-resetting source remains
  always_comb begin
    if (|(raw & ~latchClass)) begin
      next_holdCnt = 32'(HOLDOFF_COUNT);
    end else if (holdCnt != 32'h0) begin
      next_holdCnt = holdCnt - 32'h1;
    end else begin
      next_holdCnt = holdCnt;
    end
  end

  assign powerStageEnable = !enableN && (active == '0) && (holdCnt == 32'h0)
    && (initState == INIT_OK);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched <= '0;
      reportIdx <= '0;
      reportValid <= 1'b0;
      extCode <= EXT_NONE;
      holdCnt <= '0;
      initState <= INIT_START;
      tries <= '0;
      activeQ <= '0;
    end else begin
      latched <= next_latched;
      reportIdx <= next_reportIdx;
      reportValid <= next_reportValid;
      extCode <= next_extCode;
      holdCnt <= next_holdCnt;
      initState <= next_initState;
      tries <= next_tries;
      activeQ <= active;
    end
  end

  // led timebase and blink sequencer
  led_state_type ledState, next_ledState;
  logic [31:0] tickCnt, next_tickCnt;
  logic tick;
  logic [3:0] slot, next_slot;
  logic [4:0] pulsesLeft, next_pulsesLeft;

  always_comb begin
    tick = (tickCnt == 32'(LED_TICK_COUNT - 1));
    next_tickCnt = tick ? 32'h0 : tickCnt + 32'h1;
    next_ledState = ledState;
    next_slot = slot;
    next_pulsesLeft = pulsesLeft;
    if (!reportValid) begin
      next_ledState = LED_IDLE;
    end else if (tick) begin
      next_slot = slot - 4'h1;
      unique case (ledState)
        LED_IDLE: begin
          next_ledState = LED_ON;
          next_slot = LED_ON_TICKS;
          next_pulsesLeft = code;
        end
        LED_ON: begin
          if (slot == 4'h1) begin
            next_pulsesLeft = pulsesLeft - 5'h1;
            next_ledState = (pulsesLeft == 5'h1) ? LED_GAP : LED_OFF;
            next_slot = (pulsesLeft == 5'h1) ? LED_GAP_TICKS : LED_OFF_TICKS;
          end
        end
        LED_OFF: begin
          if (slot == 4'h1) begin
            next_ledState = LED_ON;
            next_slot = LED_ON_TICKS;
          end
        end
        LED_GAP: begin
          if (slot == 4'h1) begin
            next_ledState = LED_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ledState <= LED_IDLE;
      tickCnt <= '0;
      slot <= '0;
      pulsesLeft <= '0;
      statusLed <= 1'b0;
    end else begin
      ledState <= next_ledState;
      tickCnt <= next_tickCnt;
      slot <= next_slot;
      pulsesLeft <= next_pulsesLeft;
      statusLed <= (next_ledState == LED_ON);
    end
  end

  // apb slave, zero wait states
  assign enW = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign rdW = apbReq.psel && !apbReq.penable && !apbReq.pwrite;

  always_comb begin
    next_latchClass = latchClass;
    next_irqMask = irqMask;
    next_irqStatus = irqStatus | (active & ~activeQ);
    if (enW && apbReq.paddr == REG_CTRL) begin
      next_latchClass = apbReq.pwdata[NF-1:0];
    end
    if (enW && apbReq.paddr == REG_IRQ_MASK) begin
      next_irqMask = apbReq.pwdata[NF-1:0];
    end
    // a new event in the clearing cycle survives the write
    if (enW && apbReq.paddr == REG_IRQ_STATUS) begin
      next_irqStatus = (irqStatus & ~apbReq.pwdata[NF-1:0]) | (active & ~activeQ);
    end
    readWord = '0;
    badAddr = 1'b0;
    unique case (apbReq.paddr)
      REG_CTRL: readWord[NF-1:0] = latchClass;
      REG_STATUS: begin
        readWord[NF-1:0] = active;
        readWord[ST_CODE +: 5] = code;
        readWord[ST_EXT +: 2] = extCode;
        readWord[ST_PWR] = powerStageEnable;
        readWord[ST_SUB +: 3] = {faultIn.auxAbsoluteEncoderFault,
          faultIn.auxThermistorFault, faultIn.auxSerialDeviceFault};
      end
      REG_IRQ_STATUS: readWord[NF-1:0] = irqStatus;
      REG_IRQ_MASK: readWord[NF-1:0] = irqMask;
      default: badAddr = 1'b1;
    endcase
    // captured at the setup edge and held to the next setup edge, so the
    // answer stands through the access phase whatever the status does
    next_prdata = prdataQ;
    next_pslverr = pslverrQ;
    if (apbReq.psel && !apbReq.penable) begin
      next_prdata = rdW ? readWord : 32'h0;
      next_pslverr = badAddr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latchClass <= CTRL_RESET;
      irqMask <= '0;
      irqStatus <= '0;
      prdataQ <= '0;
      pslverrQ <= 1'b0;
    end else begin
      latchClass <= next_latchClass;
      irqMask <= next_irqMask;
      irqStatus <= next_irqStatus;
      prdataQ <= next_prdata;
      pslverrQ <= next_pslverr;
    end
  end
  // one driver for the whole response; every access ends at its first access edge
  assign apbRsp = '{prdata: prdataQ, pready: 1'b1, pslverr: pslverrQ};
  assign irq = |(irqStatus & irqMask);

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence selfFaultGone;
    (raw & ~latchClass) != '0 ##1 (raw & ~latchClass) == '0;
  endsequence

  a_latch_only_class: assert property (
    (raw & ~latchClass & ~latched) != '0 && !enableN |=> (latched & ~latchClass) == '0)
    else $error("self-resetting fault was latched");
  a_fault_kills_stage: assert property (
    active != '0 |-> !powerStageEnable) else $error("stage enabled with fault");
  a_holdoff_stage_off: assert property (
    selfFaultGone |-> !powerStageEnable [*8]) else $error("holdoff too short");
  a_stage_resumes: assert property (
    !enableN && initState == INIT_OK && active == '0 && holdCnt == 32'h1 ##1
    (!enableN && active == '0) |-> powerStageEnable) else $error("no auto re-enable");
  a_disable_clears: assert property (
    enableN |=> latched == '0) else $error("latch survived disable");
  a_latch_holds: assert property (
    !enableN && latched != '0 |=> (latched & $past(latched)) == $past(latched))
    else $error("latched fault lost while enabled");
  a_highest_reported: assert property (
    !reportValid && active != '0 |=> reportValid && !(|($past(active) &
      ((7'h1 << reportIdx) - 7'h1)))) else $error("wrong priority");
  a_comm_code: assert property (
    reportValid && reportIdx == 3'(F_COMM) |-> code == 5'h11) else $error("bad code 17");
  a_pos_ext: assert property (
    reportValid && reportIdx == 3'(F_POS) |-> code == 5'h13 && extCode == EXT_POS_OVF)
    else $error("bad position ext code");
  a_sync_ext: assert property (
    !reportValid && active == 7'h40 |=> extCode == EXT_NONE && code == 5'h14)
    else $error("bad sync ext code");
  a_init_tries: assert property (
    initState == INIT_FAIL |-> tries == INIT_TRIES) else $error("gave up early");
  a_led_dark_idle: assert property (
    !reportValid |=> !statusLed) else $error("led lit without fault");
  a_wdog_code: assert property (
    reportValid && reportIdx == 3'(F_WDOG) |-> code == 5'h12 && extCode == EXT_NONE)
    else $error("bad code 18");
  a_step_ext: assert property (
    reportValid && reportIdx == 3'(F_STEP) |-> code == 5'h13 && extCode == EXT_STEP_OVF)
    else $error("bad step ext code");
  a_aux_ext: assert property (
    reportValid && reportIdx == 3'(F_AUX) |-> code == 5'h14 && extCode == EXT_AUX_FB)
    else $error("bad aux ext code");
  a_aux_sub_fault: assert property (
    faultIn.auxThermistorFault || faultIn.auxSerialDeviceFault |-> active[F_AUX])
    else $error("aux sub-fault not seen");
  a_ext_stands: assert property (
    reportValid && !enableN && active[reportIdx] |=> $stable(extCode) && $stable(reportIdx))
    else $error("extended code moved while reported");
  a_stage_needs_init: assert property (
    initState != INIT_OK |-> !powerStageEnable) else $error("stage on before setup");
  a_disabled_stage_off: assert property (
    enableN |-> !powerStageEnable) else $error("stage on while disabled");

  // a gap shorter than a few cycles would read as one more pulse
  sequence lastPulseEnds;
    reportValid && tick && ledState == LED_ON && slot == 4'h1 && pulsesLeft == 5'h1;
  endsequence
  a_gap_dark: assert property (
    lastPulseEnds ##1 reportValid [*7] |-> !statusLed && ledState == LED_GAP)
    else $error("dark gap too short");
endmodule // servo_fault_manager

// ===== servo_feedback_model.sv
// serial feedback device model answering setup attempts
// assumes one initRequest pulse per attempt, answers fast and slow in turn;
// refuseSetup high makes every attempt fail
`timescale 1ns/100ps
module servo_feedback_model #(
  parameter int FAILS = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic initRequest,
  input wire logic refuseSetup,
  output logic initDone,
  output logic initOk
);
  int tries;
  int waitN;
  logic busy;
  logic okLast;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tries <= 0;
      waitN <= 0;
      busy <= 1'b0;
      initDone <= 1'b0;
      okLast <= 1'b0;
    end else begin
      initDone <= 1'b0;
      if (initRequest && !busy) begin
        busy <= 1'b1;
        waitN <= (tries % 2) ? 8 : 1;
      end else if (busy && waitN > 0) begin
        waitN <= waitN - 1;
      end else if (busy) begin
        busy <= 1'b0;
        initDone <= 1'b1;
        okLast <= (tries >= FAILS) && !refuseSetup;
        tries <= tries + 1;
      end
    end
  end
  // outside the answer the line shows the inverse, not a stale value
  assign initOk = initDone ? okLast : ~okLast;
endmodule // servo_feedback_model

// ===== servo_fault_manager_tb_top.sv
// self-checking bench for the servo fault manager
// assumes short hold-off and led tick counts set at the instance
`timescale 1ns/100ps
module servo_fault_manager_tb_top;
  import servo_fault_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_type req = '0;
  apb_rsp_type rsp;
  fault_in_type faultIn = '0;
  logic signed [31:0] followingError = '0;
  logic enableN = 1'b0;
  logic refuseSetup = 1'b0;
  logic initRequest, initDone, initOk, powerStageEnable, statusLed, irq;
  int nErrors = 0;
  int nTests = 0;
  int cycles = 0;
  logic [31:0] s;
  logic lastErr;
  logic [7:0] tFi [7] = '{8'h40, 8'h80, 8'h20, 8'h00, 8'h00, 8'h08, 8'h01};
  logic [31:0] tFe [7] = '{32'h0, 32'h0, 32'h0, 32'h0080_0001, 32'hff7f_ffff, 32'h0, 32'h0};
  logic [4:0] tCode [7] = '{5'h12, 5'h11, 5'h13, 5'h13, 5'h13, 5'h14, 5'h14};
  logic [1:0] tExt [7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};

  servo_fault_manager #(.HOLDOFF_COUNT(20), .LED_TICK_COUNT(4)) dut (.clk(clk), .rst_n(rst_n),
    .apbReq(req), .apbRsp(rsp), .faultIn(faultIn), .followingError(followingError),
    .enableN(enableN), .initRequest(initRequest), .initDone(initDone), .initOk(initOk),
    .powerStageEnable(powerStageEnable), .statusLed(statusLed), .irq(irq));
  servo_feedback_model #(.FAILS(3)) feedback (.clk(clk), .rst_n(rst_n),
    .initRequest(initRequest), .refuseSetup(refuseSetup), .initDone(initDone),
    .initOk(initOk));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (nErrors == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nErrors++;
      summarize();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // read data and error are taken at the edge that ends the access
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge clk);
    req.paddr <= a;
    req.pwrite <= w;
    req.pwdata <= d;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    lastErr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic cycleEnable();
    @(posedge clk) enableN <= 1'b1;
    @(posedge clk) enableN <= 1'b0;
    tick(3);
  endtask

  task automatic setFault(input logic [7:0] f, input logic [31:0] e);
    @(posedge clk);
    faultIn <= fault_in_type'(f);
    followingError <= e;
    tick(3);
  endtask

  task automatic initAndRegs();
    tick(2);
    check(powerStageEnable, 0);
    for (int k = 0; k < 200 && powerStageEnable !== 1'b1; k++) tick(1);
    check(powerStageEnable, 1);
    check(feedback.tries, 4);
    apb(REG_CTRL, 1'b0, 32'h0, s);
    check(s, 32'h7f);
    apb(REG_IRQ_MASK, 1'b0, 32'h0, s);
    check(s, 32'h0);
    apb(8'h10, 1'b0, 32'h0, s);
    check(s, 32'h0);
    check(lastErr, 1'b1);
  endtask

  task automatic codeTable();
    for (int i = 0; i < 7; i++) begin
      setFault(tFi[i], tFe[i]);
      check(powerStageEnable, 0);
      apb(REG_STATUS, 1'b0, 32'h0, s);
      check({s[12:8], s[17:16]}, {tCode[i], tExt[i]});
      setFault(8'h00, 32'h0);
      check(powerStageEnable, 0);
      cycleEnable();
      check(powerStageEnable, 1);
    end
    setFault(8'h00, 32'h0080_0000);
    check(powerStageEnable, 1);
    setFault(8'h00, 32'h0);
  endtask

  task automatic selfReset();
    apb(REG_CTRL, 1'b1, 32'h7d, s);
    setFault(8'h80, 32'h0);
    check(powerStageEnable, 0);
    setFault(8'h00, 32'h0);
    tick(12);
    check(powerStageEnable, 0);
    tick(15);
    check(powerStageEnable, 1);
    apb(REG_CTRL, 1'b1, 32'h7f, s);
  endtask

  task automatic priorityOrder();
    setFault(8'h41, 32'h0);
    apb(REG_STATUS, 1'b0, 32'h0, s);
    check(s[12:8], 5'h12);
    setFault(8'h01, 32'h0);
    cycleEnable();
    apb(REG_STATUS, 1'b0, 32'h0, s);
    check({s[12:8], s[17:16]}, {5'h14, 2'h0});
    setFault(8'h00, 32'h0);
    cycleEnable();
    check(powerStageEnable, 1);
  endtask

  task automatic irqFlow();
    apb(REG_IRQ_STATUS, 1'b1, 32'h7f, s);
    apb(REG_IRQ_MASK, 1'b1, 32'h04, s);
    tick(1);
    check(irq, 0);
    setFault(8'h40, 32'h0);
    check(irq, 1);
    apb(REG_IRQ_MASK, 1'b1, 32'h0, s);
    tick(1);
    check(irq, 0);
    apb(REG_IRQ_MASK, 1'b1, 32'h04, s);
    setFault(8'h00, 32'h0);
    cycleEnable();
    apb(REG_IRQ_STATUS, 1'b1, 32'h04, s);
    tick(1);
    check(irq, 0);
  endtask

  // counts one whole pulse train, framed by the long dark gap on both sides
  task automatic ledBlink();
    int dark;
    int pulses;
    logic prev;
    dark = 0;
    pulses = 0;
    prev = 1'b0;
    setFault(8'h40, 32'h0);
    for (int k = 0; k < 100 && statusLed !== 1'b1; k++) tick(1);
    for (int k = 0; k < 600 && dark < 20; k++) begin
      tick(1);
      dark = statusLed ? 0 : dark + 1;
    end
    for (int k = 0; k < 100 && statusLed !== 1'b1; k++) tick(1);
    dark = 0;
    for (int k = 0; k < 600 && dark < 20; k++) begin
      if (statusLed && !prev) pulses++;
      prev = statusLed;
      dark = statusLed ? 0 : dark + 1;
      tick(1);
    end
    check(pulses, 18);
    setFault(8'h00, 32'h0);
    cycleEnable();
    check(statusLed, 0);
  endtask

  // mid-run power cycles: a dead feedback device, then a healthy one
  task automatic initFailure();
    @(posedge clk);
    rst_n <= 1'b0;
    refuseSetup <= 1'b1;
    tick(3);
    check(powerStageEnable, 0);
    @(posedge clk) rst_n <= 1'b1;
    for (int k = 0; k < 300 && feedback.tries < 4; k++) tick(1);
    tick(3);
    apb(REG_STATUS, 1'b0, 32'h0, s);
    check({s[12:8], s[6:0]}, {5'h0c, 7'h01});
    check(powerStageEnable, 0);
    cycleEnable();
    check(powerStageEnable, 0);
    @(posedge clk);
    rst_n <= 1'b0;
    refuseSetup <= 1'b0;
    tick(3);
    @(posedge clk) rst_n <= 1'b1;
    for (int k = 0; k < 200 && powerStageEnable !== 1'b1; k++) tick(1);
    check(powerStageEnable, 1);
  endtask

  initial begin
    repeat (11) @(posedge clk);
    #1;
    check({powerStageEnable, statusLed, irq}, 3'h0);
    @(posedge clk) rst_n <= 1'b1;
    initAndRegs();
    codeTable();
    selfReset();
    priorityOrder();
    ledBlink();
    irqFlow();
    initFailure();
    summarize();
  end
endmodule // servo_fault_manager_tb_top
